// [verilog/csct_consts.vh]
/*
 * Constants for the clock source control, trim and status block:
 * register byte offsets, reset values, mode codes, bus response codes
 * and start-up/synchronisation counts.
 * Assumes inclusion by the block's design file and its test bench.
 */
// How it works
// - Bus clock divides by 1, 2, 4, 8
// - Divider field resets to divide by two
// - Bit 5 picks oscillator high or low range
// - Bit 4 picks high gain or low power
// - Low-power bit stops loop when bypassed, not debugging
// - Bit 2 requests crystal or external clock
// - Bit 1 enables external reference clock output
// - Stop keeps output only with both enables
// - Coarse trim eight bits, binary weighted
// - Larger coarse trim gives longer period
// - Fine trim bit adds smallest period step
// - Trims survive system reset; fine clears at power-on
// - Status bits 7:5 read zero
// - Reference status follows select after synchronisation
// - Mode status follows clock select after synchronisation
// - Clock select codes; code 11 acts as 00
// - Oscillator ready sets after start-up cycles
// - Oscillator ready clears only on system reset or when enable or request clears
`ifndef CSCT_CONSTS_VH
`define CSCT_CONSTS_VH

`define CSCT_OFF_CTRL1      4'h0
`define CSCT_OFF_CTRL2      4'h4
`define CSCT_OFF_TRIM       4'h8
`define CSCT_OFF_STATUS     4'hc
`define CSCT_OFF_IRQ_STAT   5'h10
`define CSCT_OFF_IRQ_CLR    5'h14
`define CSCT_OFF_IRQ_EN     5'h18

`define CSCT_CTRL1_RESET    8'h04
`define CSCT_CTRL2_RESET    8'h40
`define CSCT_TRIM_RESET     8'h80

`define CSCT_CS_LOOP        2'h0
`define CSCT_CS_INT         2'h1
`define CSCT_CS_EXT         2'h2
`define CSCT_CS_RSVD        2'h3

`define CSCT_SYNC_CYCLES    4'h4
`define CSCT_OSC_INIT_CYC   12'h800

`define CSCT_RESP_OKAY      2'h0
`define CSCT_RESP_SLVERR    2'h2

`endif

// [verilog/csct_clock_ctrl.v]
/*
 * Clock source control, trim and status register block with an
 * AXI4-Lite slave, a bus clock divider, oscillator configuration
 * outputs and an interrupt on status changes.
 * Assumes one clock, a synchronous reset and a separate power-on
 * reset input; debug, stop and the selected source arrive as pins.
 */
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`include "csct_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module csct_clock_ctrl (
    // Clock and resets
    input  wire        clk_in,
    input  wire        rst_in,
    input  wire        por_in,
    // AXI4-Lite write
    input  wire [4:0]  s_axi_awaddr_in,
    input  wire        s_axi_awvalid_in,
    output reg         s_axi_awready_out,
    input  wire [31:0] s_axi_wdata_in,
    input  wire [3:0]  s_axi_wstrb_in,
    input  wire        s_axi_wvalid_in,
    output reg         s_axi_wready_out,
    output reg  [1:0]  s_axi_bresp_out,
    output reg         s_axi_bvalid_out,
    input  wire        s_axi_bready_in,
    // AXI4-Lite read
    input  wire [4:0]  s_axi_araddr_in,
    input  wire        s_axi_arvalid_in,
    output reg         s_axi_arready_out,
    output reg  [31:0] s_axi_rdata_out,
    output reg  [1:0]  s_axi_rresp_out,
    output reg         s_axi_rvalid_out,
    input  wire        s_axi_rready_in,
    // System pins
    input  wire        debug_mode_active_in,
    input  wire        stop_mode_in,
    input  wire        src_clk_in,
    // Clock outputs, configuration and interrupt
    output reg         bus_clk_out,
    output reg         osc_high_range_out,
    output reg         osc_high_gain_out,
    output reg         ext_ref_source_sel_out,
    output reg         ext_ref_clock_out,
    output reg         loop_enable_out,
    output reg  [8:0]  ref_trim_out,
    output reg  [1:0]  clock_select_out,
    output reg         ref_select_out,
    output reg         irq_out
);

////////////////////////////////////////////////////////////////////////
// Registers
reg  [7:0]  ctrl1_r;
reg  [7:0]  ctrl2_r;
reg  [7:0]  trim_r;
reg         fine_trim_r;
reg         ref_source_status_r;
reg  [1:0]  clock_mode_status_r;
reg         osc_ready_r;
reg  [2:0]  irq_stat_r;
reg  [2:0]  irq_en_r;

// Synchronisers for outside pins
reg  [2:0]  pin_s1_r;
reg  [2:0]  pin_s2_r;
reg         src_prev_r;

// Delayed status tracking and bus clock division
reg  [3:0]  sync_cnt_r;
reg  [11:0] osc_cnt_r;
reg  [2:0]  div_cnt_r;

// Bus slave state
reg         aw_held_r;
reg         w_held_r;
reg  [4:0]  aw_addr_r;
reg  [31:0] w_data_r;
reg  [3:0]  w_strb_r;

wire        dbg_s       = pin_s2_r[0];
wire        stop_s      = pin_s2_r[1];
wire        src_s       = pin_s2_r[2];
wire [1:0]  bus_divider = ctrl2_r[7:6];
wire        lp_bit      = ctrl2_r[3];
wire        ext_ref_source_sel_bit   = ctrl2_r[2];
wire        ext_ref_out_en_bit = ctrl2_r[1];
wire        ext_ref_stop_en    = ctrl2_r[0];
wire [1:0]  cs_raw      = ctrl1_r[7:6];
wire [1:0]  cs_eff      = (cs_raw == `CSCT_CS_RSVD) ? `CSCT_CS_LOOP : cs_raw;
wire        ref_select_bit   = ctrl1_r[2];
wire        ext_mode    = (cs_eff == `CSCT_CS_EXT) || !ref_select_bit;
wire        osc_wanted  = ext_ref_source_sel_bit && (ext_ref_out_en_bit || ext_mode);
wire [7:0]  status_rd   = {3'h0, ref_source_status_r, clock_mode_status_r,
                           osc_ready_r, fine_trim_r};

////////////////////////////////////////////////////////////////////////
// Write channel
wire        wr_go   = aw_held_r && w_held_r && !s_axi_bvalid_out;
wire        wr_ctl1 = wr_go && (aw_addr_r[4:2] == `CSCT_OFF_CTRL1 >> 2) && w_strb_r[0];
wire        wr_ctl2 = wr_go && (aw_addr_r[4:2] == `CSCT_OFF_CTRL2 >> 2) && w_strb_r[0];
wire        wr_trim = wr_go && (aw_addr_r[4:2] == `CSCT_OFF_TRIM >> 2) && w_strb_r[0];
wire        wr_stat = wr_go && (aw_addr_r[4:2] == `CSCT_OFF_STATUS >> 2) && w_strb_r[0];
wire        wr_iclr = wr_go && (aw_addr_r == `CSCT_OFF_IRQ_CLR) && w_strb_r[0];
wire        wr_ien  = wr_go && (aw_addr_r == `CSCT_OFF_IRQ_EN) && w_strb_r[0];
wire        wr_ok   = wr_ctl1 || wr_ctl2 || wr_trim || wr_stat || wr_iclr || wr_ien ||
                      (wr_go && (aw_addr_r == `CSCT_OFF_IRQ_STAT));

always @(posedge clk_in) begin
    if (rst_in) begin
        aw_held_r         <= 1'b0;
        w_held_r          <= 1'b0;
        aw_addr_r         <= 5'h00;
        w_data_r          <= 32'h0000_0000;
        w_strb_r          <= 4'h0;
        s_axi_awready_out <= 1'b0;
        s_axi_wready_out  <= 1'b0;
        s_axi_bvalid_out  <= 1'b0;
        s_axi_bresp_out   <= `CSCT_RESP_OKAY;
    end else begin
        s_axi_awready_out <= !aw_held_r && !s_axi_awready_out && !s_axi_bvalid_out;
        s_axi_wready_out  <= !w_held_r && !s_axi_wready_out && !s_axi_bvalid_out;
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr_in;
            s_axi_awready_out <= 1'b0;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata_in;
            w_strb_r <= s_axi_wstrb_in;
            s_axi_wready_out <= 1'b0;
        end
        if (wr_go) begin
            aw_held_r        <= 1'b0;
            w_held_r         <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= wr_ok ? `CSCT_RESP_OKAY : `CSCT_RESP_SLVERR;
        end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Read channel
always @(posedge clk_in) begin
    if (rst_in) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b0;
        s_axi_rdata_out   <= 32'h0000_0000;
        s_axi_rresp_out   <= `CSCT_RESP_OKAY;
    end else begin
        s_axi_arready_out <= !s_axi_arready_out && !s_axi_rvalid_out;
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rresp_out   <= `CSCT_RESP_OKAY;
            if (s_axi_araddr_in[4:2] == `CSCT_OFF_CTRL1 >> 2) begin
                s_axi_rdata_out <= {24'h000000, ctrl1_r};
            end else if (s_axi_araddr_in[4:2] == `CSCT_OFF_CTRL2 >> 2) begin
                s_axi_rdata_out <= {24'h000000, ctrl2_r};
            end else if (s_axi_araddr_in[4:2] == `CSCT_OFF_TRIM >> 2) begin
                s_axi_rdata_out <= {24'h000000, trim_r};
            end else if (s_axi_araddr_in[4:2] == `CSCT_OFF_STATUS >> 2) begin
                s_axi_rdata_out <= {24'h000000, status_rd};
            end else if (s_axi_araddr_in == `CSCT_OFF_IRQ_STAT) begin
                s_axi_rdata_out <= {29'h00000000, irq_stat_r};
            end else if (s_axi_araddr_in == `CSCT_OFF_IRQ_CLR) begin
                s_axi_rdata_out <= 32'h0000_0000;
            end else if (s_axi_araddr_in == `CSCT_OFF_IRQ_EN) begin
                s_axi_rdata_out <= {29'h00000000, irq_en_r};
            end else begin
                s_axi_rdata_out <= 32'h0000_0000;
                s_axi_rresp_out <= `CSCT_RESP_SLVERR;
            end
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Control registers; trims keep their value over system reset
always @(posedge clk_in) begin
    if (rst_in) begin
        ctrl1_r <= `CSCT_CTRL1_RESET;
        ctrl2_r <= `CSCT_CTRL2_RESET;
    end else begin
        if (wr_ctl1) begin
            ctrl1_r <= w_data_r[7:0];
        end
        if (wr_ctl2) begin
            ctrl2_r <= w_data_r[7:0];
        end
    end
end

always @(posedge clk_in) begin
    if (por_in) begin
        trim_r      <= `CSCT_TRIM_RESET;
        fine_trim_r <= 1'b0;
    end else begin
        if (wr_trim) begin
            trim_r <= w_data_r[7:0];
        end
        if (wr_stat) begin
            fine_trim_r <= w_data_r[0];
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Pin synchronisers and delayed status
always @(posedge clk_in) begin
    if (rst_in) begin
        pin_s1_r <= 3'h0;
        pin_s2_r <= 3'h0;
    end else begin
        pin_s1_r <= {src_clk_in, stop_mode_in, debug_mode_active_in};
        pin_s2_r <= pin_s1_r;
    end
end

// Status only moves after selections stay stable for the sync count
always @(posedge clk_in) begin
    if (rst_in) begin
        sync_cnt_r          <= 4'h0;
        ref_source_status_r <= 1'b1;
        clock_mode_status_r <= `CSCT_CS_LOOP;
    end else if (wr_ctl1) begin
        sync_cnt_r <= 4'h0;
    end else if (sync_cnt_r != `CSCT_SYNC_CYCLES) begin
        sync_cnt_r <= sync_cnt_r + 4'h1;
    end else begin
        ref_source_status_r <= ref_select_bit;
        clock_mode_status_r <= cs_eff;
    end
end

// Start-up wait of the oscillator; cleared only by system reset or by dropping the output enable or the request
always @(posedge clk_in) begin
    if (rst_in) begin
        osc_cnt_r   <= 12'h000;
        osc_ready_r <= 1'b0;
    end else if (!ext_ref_out_en_bit || !ext_ref_source_sel_bit) begin
        osc_cnt_r   <= 12'h000;
        osc_ready_r <= 1'b0;
    end else if (osc_wanted && !osc_ready_r) begin
        if (osc_cnt_r == `CSCT_OSC_INIT_CYC) begin
            osc_ready_r <= 1'b1;
        end else begin
            osc_cnt_r <= osc_cnt_r + 12'h001;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Bus clock divider and configuration outputs
// The source is sampled, not used as a clock, so the bus clock
// is only as fine as the system clock; a source faster than half
// the system clock cannot be followed.
// Toggling every div_top+1 source edges gives a full bus period
// of that many source periods.
wire        src_rise = src_s && !src_prev_r;
wire [2:0]  div_top  = (3'h1 << bus_divider) - 3'h1;

always @(posedge clk_in) begin
    if (rst_in) begin
        src_prev_r  <= 1'b0;
        div_cnt_r   <= 3'h0;
        bus_clk_out <= 1'b0;
    end else begin
        src_prev_r <= src_s;
        if (bus_divider == 2'h0) begin
            bus_clk_out <= src_s;
            div_cnt_r   <= 3'h0;
        end else if (src_s != src_prev_r) begin
            // Greater-or-equal so a smaller divider written mid-count
            // still wraps at once instead of running on to seven
            if (div_cnt_r >= div_top) begin
                div_cnt_r   <= 3'h0;
                bus_clk_out <= !bus_clk_out;
            end else begin
                div_cnt_r <= div_cnt_r + 3'h1;
            end
        end
    end
end

// Interrupt events: the reference, mode and oscillator ready status fields each flag a change once they move
// Last oscillator ready level, for its change event
reg         osc_wanted_prev;
wire        mode_chg = (sync_cnt_r == `CSCT_SYNC_CYCLES) && (clock_mode_status_r != cs_eff);
wire        ref_chg  = (sync_cnt_r == `CSCT_SYNC_CYCLES) && (ref_source_status_r != ref_select_bit);
wire [2:0]  irq_evt = {osc_ready_r ^ osc_wanted_prev, mode_chg, ref_chg};

always @(posedge clk_in) begin
    if (rst_in) begin
        osc_high_range_out     <= 1'b0;
        osc_high_gain_out      <= 1'b0;
        ext_ref_source_sel_out <= 1'b0;
        ext_ref_clock_out      <= 1'b0;
        loop_enable_out        <= 1'b1;
        // Trims survive a system reset, so their output does too
        ref_trim_out           <= {trim_r, fine_trim_r};
        clock_select_out       <= `CSCT_CS_LOOP;
        ref_select_out         <= 1'b1;
        irq_stat_r             <= 3'h0;
        irq_en_r               <= 3'h0;
        irq_out                <= 1'b0;
        osc_wanted_prev        <= 1'b0;
    end else begin
        osc_high_range_out     <= ctrl2_r[5];
        osc_high_gain_out      <= ctrl2_r[4];
        ext_ref_source_sel_out <= ext_ref_source_sel_bit;
        ext_ref_clock_out      <= ext_ref_out_en_bit && (!stop_s || ext_ref_stop_en);
        loop_enable_out        <= !stop_s && !(lp_bit && !dbg_s &&
                                  (clock_mode_status_r != `CSCT_CS_LOOP));
        ref_trim_out           <= {trim_r, fine_trim_r};
        clock_select_out       <= cs_eff;
        ref_select_out         <= ref_select_bit;
        osc_wanted_prev        <= osc_ready_r;
        if (wr_ien) begin
            irq_en_r <= w_data_r[2:0];
        end
        // A new event wins over a clear in the same cycle
        irq_stat_r <= (irq_stat_r & ~(wr_iclr ? w_data_r[2:0] : 3'h0)) | irq_evt;
        irq_out    <= |(irq_stat_r & irq_en_r);
    end
end

endmodule

`default_nettype wire

// [verification/csct_clock_ctrl_assertions.sv]
/* Port checker for the clock control block.
   Assumes it is bound to csct_clock_ctrl. */
`timescale 1ns/10ps
`default_nettype none
module csct_clock_ctrl_assertions (
    // Clock and resets
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        por_in,
    // Bus
    input wire logic [4:0]  s_axi_araddr_in,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0]  s_axi_rresp_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic        s_axi_rready_in,
    input wire logic [1:0]  s_axi_bresp_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_bready_in,
    // Mode pins and clock outputs
    input wire logic        debug_mode_active_in,
    input wire logic        stop_mode_in,
    input wire logic        loop_enable_out,
    input wire logic [8:0]  ref_trim_out,
    input wire logic [1:0]  clock_select_out
);
default clocking @(posedge clk_in);
endclocking
default disable iff (rst_in || por_in);
////////////////////////////////////////////////////////////
chk_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("bvalid dropped");
chk_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("rvalid dropped");
chk_stat_reserved: assert property (
    s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == 5'h0c
    |=> s_axi_rvalid_out && s_axi_rdata_out[7:5] == 3'h0) else $error("reserved set");
chk_unmapped_read: assert property (
    s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == 5'h1c
    |=> s_axi_rresp_out == 2'h2 && s_axi_rdata_out == 32'h0) else $error("bad unmapped");
chk_select_code: assert property (clock_select_out != 2'h3)
    else $error("select 11 passed");
chk_stop_loop: assert property (stop_mode_in [*4] |=> !loop_enable_out)
    else $error("loop on in stop");
chk_debug_loop: assert property (
    (debug_mode_active_in && !stop_mode_in) [*4] |=> loop_enable_out)
    else $error("loop off in debug");
chk_trim_keep: assert property (
    disable iff (por_in) rst_in |=> $stable(ref_trim_out)) else $error("trim lost");
endmodule
bind csct_clock_ctrl csct_clock_ctrl_assertions u_chk (
    .clk_in(clk_in), .rst_in(rst_in), .por_in(por_in),
    .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in), .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .debug_mode_active_in(debug_mode_active_in), .stop_mode_in(stop_mode_in),
    .loop_enable_out(loop_enable_out), .ref_trim_out(ref_trim_out),
    .clock_select_out(clock_select_out));
`default_nettype wire

// [verification/csct_clock_ctrl_test.sv]
/* Self-checking bench for csct_clock_ctrl.
   Assumes csct_consts.vh is on the include path. */
`include "csct_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module csct_clock_ctrl_test;
localparam logic [4:0] A_C1 = {1'b0, `CSCT_OFF_CTRL1};
localparam logic [4:0] A_C2 = {1'b0, `CSCT_OFF_CTRL2};
localparam logic [4:0] A_TR = {1'b0, `CSCT_OFF_TRIM};
localparam logic [4:0] A_ST = {1'b0, `CSCT_OFF_STATUS};
logic        clk_in = 0, rst_in = 1, por_in = 1;
logic [4:0]  aw = 0, ar = 0;
logic [31:0] wd = 0, seed = 32'h8af0;
logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0, dbg = 0, stp = 0, src = 0;
logic        awr, wrd, bv, arr, rv, bclk, bq = 0, hr, hg, es, ec, le, rs, irq;
logic [1:0]  bresp, rresp, cs;
logic [31:0] rdata;
logic [8:0]  trim;
logic [7:0]  v, st = 8'h10;
logic [7:0]  c1v[4] = '{8'h44, 8'h84, 8'hc4, 8'h00};
logic [7:0]  stv[4] = '{8'h14, 8'h18, 8'h10, 8'h00};
int          errors = 0, check_count = 0, edges = 0, i, n;
csct_clock_ctrl uut (.clk_in(clk_in), .rst_in(rst_in), .por_in(por_in),
    .s_axi_awaddr_in(aw), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrd), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(br), .s_axi_araddr_in(ar), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .debug_mode_active_in(dbg),
    .stop_mode_in(stp), .src_clk_in(src), .bus_clk_out(bclk),
    .osc_high_range_out(hr), .osc_high_gain_out(hg), .ext_ref_source_sel_out(es),
    .ext_ref_clock_out(ec), .loop_enable_out(le), .ref_trim_out(trim),
    .clock_select_out(cs), .ref_select_out(rs), .irq_out(irq));
always #50 clk_in = ~clk_in;
// Source toggles every cycle; bus edges counted for the divider
always @(posedge clk_in) begin
    src <= ~src;
    bq <= bclk;
    if (bclk && !bq) edges <= edges + 1;
end
////////////////////////////////////////////////////////////
function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
endfunction
task automatic tally_and_finish;
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
endtask
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
        errors++;
        $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
endtask
task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
endtask
task automatic hang(input int k);
    if (k == 100) begin
        errors++;
        $display("[FAIL] %0t bus timeout", $time);
        tally_and_finish;
    end
endtask
task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int k;
    aw <= a;
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    br <= 1;
    for (k = 0; k < 100; k++) begin
        @(posedge clk_in);
        if (awv && awr) awv <= 0;
        if (wv && wrd) wv <= 0;
        if (bv) break;
    end
    hang(k);
    chk({30'h0, bresp}, `CSCT_RESP_OKAY);
    br <= 0;
    @(posedge clk_in);
endtask
task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [1:0] er);
    int k;
    ar <= a;
    arv <= 1;
    rr <= 1;
    for (k = 0; k < 100; k++) begin
        @(posedge clk_in);
        if (arv && arr) arv <= 0;
        if (rv) break;
    end
    hang(k);
    chk(rdata, {24'h0, e});
    chk({30'h0, rresp}, {30'h0, er});
    rr <= 0;
    @(posedge clk_in);
endtask
////////////////////////////////////////////////////////////
initial begin
    cyc(5);
    rst_in <= 0;
    por_in <= 0;
    rd(A_C2, `CSCT_CTRL2_RESET, 0);
    rd(A_ST, 8'h10, 0);
    chk(trim, {`CSCT_TRIM_RESET, 1'b0});
    for (i = 0; i < 4; i++) begin
        seed = xs(seed);
        v = seed[7:0];
        wr(A_C2, v);
        chk(hr, v[5]);
        chk(hg, v[4]);
        chk(es, v[2]);
        chk(ec, v[1]);
        rd(A_C2, v, 0);
    end
    for (i = 0; i < 4; i++) begin
        wr(A_C2, {i[1:0], 6'h0});
        cyc(8);
        n = edges;
        cyc(128);
        n = edges - n;
        chk(n >= (64 >> i) - 1 && n <= (64 >> i) + 1, 1);
    end
    seed = xs(seed);
    v = seed[7:0];
    wr(A_TR, v);
    wr(A_ST, 8'hff);
    rd(A_ST, 8'h11, 0);
    chk(trim, {v, 1'b1});
    rst_in <= 1;
    cyc(5);
    rst_in <= 0;
    rd(A_TR, v, 0);
    rd(A_ST, 8'h11, 0);
    rst_in <= 1;
    por_in <= 1;
    cyc(5);
    rst_in <= 0;
    por_in <= 0;
    rd(A_ST, 8'h10, 0);
    rd(5'h1c, 8'h00, `CSCT_RESP_SLVERR);
    wr(A_C2, 8'h08);
    for (i = 0; i < 4; i++) begin
        wr(A_C1, c1v[i]);
        cyc(10);
        st = stv[i];
        rd(A_ST, st, 0);
        chk(cs, st[3:2]);
        chk(rs, c1v[i][2]);
        chk(le, st[3:2] == 2'h0);
        dbg <= 1;
        cyc(6);
        chk(le, 1);
        dbg <= 0;
    end
    wr(`CSCT_OFF_IRQ_EN, 8'h04);
    wr(`CSCT_OFF_IRQ_CLR, 8'h07);
    wr(A_C2, 8'h06);
    cyc(2100);
    rd(A_ST, 8'h02, 0);
    chk(irq, 1);
    wr(`CSCT_OFF_IRQ_CLR, 8'h04);
    cyc(2);
    chk(irq, 0);
    stp <= 1;
    cyc(6);
    chk(ec, 0);
    wr(A_C2, 8'h07);
    cyc(2);
    chk(ec, 1);
    stp <= 0;
    wr(A_C2, 8'h04);
    cyc(4);
    rd(A_ST, 8'h00, 0);
    chk(irq, 1);
    rd(`CSCT_OFF_IRQ_STAT, 8'h04, 0);
    tally_and_finish;
end
endmodule
`default_nettype wire
